// File: core/spsm_defs.vh
/*
 Constants for the serial port status and mode block: register offsets,
 field positions, reset values and the state encodings of the engines.
 Assumes inclusion by bare name from the core files only.
*/
`ifndef SPSM_DEFS_VH
`define SPSM_DEFS_VH

// Byte addresses on the register bus
`define SPSM_OFS_MODE      6'h00
`define SPSM_OFS_BRATE     6'h04
`define SPSM_OFS_CTRL      6'h08
`define SPSM_OFS_TXDATA    6'h0c
`define SPSM_OFS_STAT      6'h10
`define SPSM_OFS_RXDATA    6'h14
`define SPSM_OFS_MODEXT    6'h18
`define SPSM_OFS_IRQ_STAT  6'h1c
`define SPSM_OFS_IRQ_MASK  6'h20
`define SPSM_MODEXT_IDX    8'hde

// Serial mode register fields
`define SPSM_MODE_SYNC     7

// Serial control register fields
`define SPSM_CTRL_TIE      7
`define SPSM_CTRL_RIE      6
`define SPSM_CTRL_TE       5
`define SPSM_CTRL_RE       4

// Serial status register fields
`define SPSM_STAT_TXE      7
`define SPSM_STAT_RXF      6
`define SPSM_STAT_ORER     5
`define SPSM_STAT_FER      4
`define SPSM_STAT_PER      3
`define SPSM_STAT_TEND     2
`define SPSM_STAT_FLAGS    8'hf8
`define SPSM_STAT_RST      8'h04

// Mode extension register fields and reset value
`define SPSM_MX_ORDER      3
`define SPSM_MX_INV        2
`define SPSM_MX_EXT        0
`define SPSM_MX_RST        8'hf2
`define SPSM_MX_WMASK      8'h0d

// Interrupt status bits
`define SPSM_IRQ_TXE       0
`define SPSM_IRQ_RXF       1
`define SPSM_IRQ_ERR       2
`define SPSM_IRQ_W         3

// Reset value of the bit rate register
`define SPSM_BRATE_RST     8'hff

// Shift engine states, one-hot
`define SPSM_ST_IDLE       4'h1
`define SPSM_ST_START      4'h2
`define SPSM_ST_DATA       4'h4
`define SPSM_ST_STOP       4'h8

// Oversampling ratio in asynchronous mode and bits per character
`define SPSM_OVS           5'h10
`define SPSM_BITS          4'h8

`endif

// File: core/spsm_rate.v
/*
 Bit rate enable divider for the serial port.
 Assumes a single clock; produces one-cycle tick pulses at clk/(div+1).
*/
module spsm_rate #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire         rst_b_i,
  input  wire         run_i,
  input  wire [W-1:0] div_i,
  output reg          tick_o
);

  reg [W-1:0] cnt;

  // Reload counter; held cleared while idle so ticks align to a start
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt    <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt    <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt == div_i) begin
      cnt    <= {W{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + {{(W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end

endmodule

// File: core/spsm_top.v
/*
 Serial port status and mode block: transmit and receive shift engines,
 status flags, mode extension register, Avalon-MM register slave and a
 masked interrupt output.
 Assumes one 25 MHz clock, an Avalon-MM master and an external serial
 partner on the line pins, which are synchronised here.
*/
// Decided for this implementation: register access over Avalon-MM.
// Overview of operation
// - Mode bit 0 selects asynchronous framing, 1 clocked synchronous.
// - The transmit-empty request is raised only while its enable is 1.
// - A character received without error sets the receive-full flag.
// - Receive-full clears only on a 0 write after a read that saw 1.
// - Loading the shift register from the buffer sets transmit-empty.
// - Clearing the transmit enable bit also sets transmit-empty.
// - Transmit-empty clears only on a 0 write after a read that saw 1.
// - Status bits 7 to 3 clear on a 0 write after a read that saw 1; writing 1 does nothing.
// - Order select 0 sends and stores LSB first, 1 MSB first.
`include "spsm_defs.vh"
module spsm_top #(
  parameter DW = 8
) (
  input  wire          clk_i,
  input  wire          rst_b_i,
  input  wire [5:0]    avs_address_i,
  input  wire          avs_read_i,
  input  wire          avs_write_i,
  input  wire [31:0]   avs_writedata_i,
  input  wire [3:0]    avs_byteenable_i,
  output reg  [31:0]   avs_readdata_o,
  output reg           avs_waitrequest_o,
  input  wire          rxd_i,
  input  wire          sck_i,
  output reg           txd_o,
  output reg           sck_o,
  output reg           sck_oe_o,
  output reg           irq_o,
  output reg           tx_empty_irq_o
);

  reg [7:0]    mode_reg;
  reg [7:0]    brate;
  reg [7:0]    serial_control_reg;
  reg [DW-1:0] transmit_data_buffer;
  reg [DW-1:0] receive_data_buffer;
  reg [7:0]    stat;
  reg [7:0]    serial_mode_extension;
  reg [`SPSM_IRQ_W-1:0] irq_stat;
  reg [`SPSM_IRQ_W-1:0] irq_mask;
  reg [7:0]    stat_seen;
  reg          ack;

  wire sync_mode  = mode_reg[`SPSM_MODE_SYNC];
  wire tx_en      = serial_control_reg[`SPSM_CTRL_TE];
  wire rx_en      = serial_control_reg[`SPSM_CTRL_RE];
  wire order_msb  = serial_mode_extension[`SPSM_MX_ORDER];
  wire inv        = serial_mode_extension[`SPSM_MX_INV];
  wire normal     = ~serial_mode_extension[`SPSM_MX_EXT];
  wire tx_empty_flag = stat[`SPSM_STAT_TXE];
  wire rx_full_flag  = stat[`SPSM_STAT_RXF];

  // Bus strobes; one wait cycle, answer on the second edge
  wire req  = (avs_read_i | avs_write_i) & ~ack;
  wire wr   = avs_write_i & ack & avs_byteenable_i[0];
  wire [7:0] wd = avs_writedata_i[7:0];

  // Pin synchronisers; the first stage feeds only the second
  reg rxd_m, rxd_s, sck_m, sck_s, sck_d;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      sck_m <= 1'b1;
      sck_s <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      rxd_m <= rxd_i;
      rxd_s <= rxd_m;
      sck_m <= sck_i;
      sck_s <= sck_m;
      sck_d <= sck_s;
    end
  end
  wire ext_rise = sck_s & ~sck_d;

  // Rate divider runs whenever either direction is enabled
  wire tick;
  spsm_rate #(.W(8)) u_rate (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .run_i   (tx_en | rx_en),
    .div_i   (brate),
    .tick_o  (tick)
  );

  // Transmit engine; sync mode shifts one bit per tick pair, own clock out
  reg [3:0]    tx_st;
  reg [DW-1:0] transmit_shift_reg;
  reg [3:0]    tx_bit;
  reg [4:0]    tx_ovs;
  reg          tx_load;
  wire         tx_step = sync_mode ? (tick & ~sck_o) :
                         (tick & (tx_ovs == `SPSM_OVS - 5'h1));
  wire         tx_out  = order_msb ? transmit_shift_reg[DW-1] :
                         transmit_shift_reg[0];

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_st              <= `SPSM_ST_IDLE;
      transmit_shift_reg <= {DW{1'b0}};
      tx_bit             <= 4'h0;
      tx_ovs             <= 5'h00;
      tx_load            <= 1'b0;
      txd_o              <= 1'b1;
      sck_o              <= 1'b1;
      sck_oe_o           <= 1'b0;
    end else begin
      tx_load  <= 1'b0;
      sck_oe_o <= sync_mode & normal;
      if (tick)
        tx_ovs <= (tx_ovs == `SPSM_OVS - 5'h1) ? 5'h00 : tx_ovs + 5'h1;
      if (tick & sync_mode & (tx_st == `SPSM_ST_DATA))
        sck_o <= ~sck_o;
      case (tx_st)
        `SPSM_ST_IDLE: begin
          sck_o <= 1'b1;
          if (tx_en & normal & ~tx_empty_flag) begin
            transmit_shift_reg <= transmit_data_buffer;
            tx_load            <= 1'b1;
            tx_bit             <= 4'h0;
            tx_ovs             <= 5'h00;
            tx_st <= sync_mode ? `SPSM_ST_DATA : `SPSM_ST_START;
            if (!sync_mode)
              txd_o <= 1'b0;
          end
        end
        `SPSM_ST_START: begin
          if (tx_step) begin
            txd_o <= tx_out ^ inv;
            tx_st <= `SPSM_ST_DATA;
          end
        end
        `SPSM_ST_DATA: begin
          // Clocked mode: data moves on the falling clock, shifts on rising
          if (sync_mode & tick & sck_o)
            txd_o <= tx_out ^ inv;
          if (tx_step) begin
            transmit_shift_reg <= order_msb ?
              {transmit_shift_reg[DW-2:0], 1'b0} :
              {1'b0, transmit_shift_reg[DW-1:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == `SPSM_BITS - 4'h1) begin
              txd_o <= sync_mode ? txd_o : 1'b1;
              tx_st <= `SPSM_ST_STOP;
            end else if (!sync_mode) begin
              txd_o <= (order_msb ? transmit_shift_reg[DW-2] :
                        transmit_shift_reg[1]) ^ inv;
            end
          end
        end
        `SPSM_ST_STOP: begin
          if (tx_step | sync_mode) begin
            txd_o <= 1'b1;
            tx_st <= `SPSM_ST_IDLE;
          end
        end
        default: tx_st <= `SPSM_ST_IDLE;
      endcase
      // Dropping the enable cuts a frame short and idles the line
      if (!(tx_en & normal)) begin
        tx_st <= `SPSM_ST_IDLE;
        txd_o <= 1'b1;
        sck_o <= 1'b1;
      end
    end
  end

  // Receive engine; async samples mid-bit, sync samples partner clock rise
  reg [3:0]    rx_st;
  reg [DW-1:0] receive_shift_reg;
  reg [3:0]    rx_bit;
  reg [4:0]    rx_ovs;
  reg          rx_done;
  reg          rx_ferr;
  wire         rx_lvl  = rxd_s ^ inv;
  wire         rx_mid  = tick & (rx_ovs == (`SPSM_OVS >> 1));
  wire         rx_samp = sync_mode ? ext_rise : rx_mid;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st             <= `SPSM_ST_IDLE;
      receive_shift_reg <= {DW{1'b0}};
      rx_bit            <= 4'h0;
      rx_ovs            <= 5'h00;
      rx_done           <= 1'b0;
      rx_ferr           <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick)
        rx_ovs <= (rx_ovs == `SPSM_OVS - 5'h1) ? 5'h00 : rx_ovs + 5'h1;
      case (rx_st)
        `SPSM_ST_IDLE: begin
          rx_bit <= 4'h0;
          if (rx_en & normal & sync_mode)
            rx_st <= `SPSM_ST_DATA;
          else if (rx_en & normal & ~rxd_s) begin
            rx_ovs <= 5'h00;
            rx_st  <= `SPSM_ST_START;
          end
        end
        `SPSM_ST_START: begin
          if (rx_mid)
            rx_st <= rxd_s ? `SPSM_ST_IDLE : `SPSM_ST_DATA;
        end
        `SPSM_ST_DATA: begin
          if (!rx_en)
            rx_st <= `SPSM_ST_IDLE;
          else if (rx_samp) begin
            receive_shift_reg <= order_msb ?
              {receive_shift_reg[DW-2:0], rx_lvl} :
              {rx_lvl, receive_shift_reg[DW-1:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == `SPSM_BITS - 4'h1) begin
              if (sync_mode) begin
                rx_done <= 1'b1;
                rx_ferr <= 1'b0;
                rx_st   <= `SPSM_ST_IDLE;
              end else
                rx_st <= `SPSM_ST_STOP;
            end
          end
        end
        `SPSM_ST_STOP: begin
          if (rx_mid) begin
            rx_done <= 1'b1;
            rx_ferr <= ~rxd_s;
            rx_st   <= `SPSM_ST_IDLE;
          end
        end
        default: rx_st <= `SPSM_ST_IDLE;
      endcase
      // A cut frame is dropped rather than left waiting for ticks
      if (!(rx_en & normal))
        rx_st <= `SPSM_ST_IDLE;
    end
  end

  // Character accepted when no framing or overrun error
  wire rx_ok   = rx_done & ~rx_ferr & ~rx_full_flag;
  wire rx_ovr  = rx_done & ~rx_ferr & rx_full_flag;
  wire rx_fe   = rx_done & rx_ferr;
  wire te_fall = wr & (avs_address_i == `SPSM_OFS_CTRL) & tx_en &
                 ~wd[`SPSM_CTRL_TE];

  // Status flags; hardware set wins over a clearing write in the same cycle
  wire       st_wr = wr & (avs_address_i == `SPSM_OFS_STAT);
  wire [7:0] clr   = st_wr ? (~wd & stat_seen & `SPSM_STAT_FLAGS) :
                     8'h00;
  reg  [7:0] next_stat;
  always @* begin
    next_stat = stat & ~clr;
    if (tx_load | te_fall)
      next_stat[`SPSM_STAT_TXE] = 1'b1;
    if (tx_load)
      next_stat[`SPSM_STAT_TEND] = 1'b0;
    else if (tx_st == `SPSM_ST_IDLE & tx_empty_flag)
      next_stat[`SPSM_STAT_TEND] = 1'b1;
    if (rx_ok)
      next_stat[`SPSM_STAT_RXF] = 1'b1;
    if (rx_ovr)
      next_stat[`SPSM_STAT_ORER] = 1'b1;
    if (rx_fe)
      next_stat[`SPSM_STAT_FER] = 1'b1;
  end

  // Registers, read tracking and bus answer
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_reg              <= 8'h00;
      brate                 <= `SPSM_BRATE_RST;
      serial_control_reg    <= 8'h00;
      transmit_data_buffer  <= {DW{1'b0}};
      receive_data_buffer   <= {DW{1'b0}};
      stat                  <= `SPSM_STAT_RST;
      serial_mode_extension <= `SPSM_MX_RST;
      irq_stat              <= {`SPSM_IRQ_W{1'b0}};
      irq_mask              <= {`SPSM_IRQ_W{1'b0}};
      stat_seen             <= 8'h00;
      ack                   <= 1'b0;
      avs_waitrequest_o     <= 1'b1;
      avs_readdata_o        <= 32'h0000_0000;
    end else begin
      ack               <= req;
      avs_waitrequest_o <= ~req;
      stat              <= next_stat;
      if (rx_ok)
        receive_data_buffer <= receive_shift_reg;
      // Only flags read as 1 are armed for a later clear
      if (req & avs_read_i & avs_address_i == `SPSM_OFS_STAT)
        stat_seen <= stat & `SPSM_STAT_FLAGS;
      else
        stat_seen <= stat_seen & ~clr;
      // Interrupt status: set wins over write-one-to-clear
      irq_stat <= (irq_stat & ~((wr & avs_address_i == `SPSM_OFS_IRQ_STAT)
                  ? wd[`SPSM_IRQ_W-1:0] : {`SPSM_IRQ_W{1'b0}}))
                | {rx_ovr | rx_fe, rx_ok, tx_load};
      if (wr) begin
        if (avs_address_i == `SPSM_OFS_MODE)
          mode_reg <= wd;
        else if (avs_address_i == `SPSM_OFS_BRATE)
          brate <= wd;
        else if (avs_address_i == `SPSM_OFS_CTRL)
          serial_control_reg <= wd;
        else if (avs_address_i == `SPSM_OFS_TXDATA)
          transmit_data_buffer <= wd[DW-1:0];
        else if (avs_address_i == `SPSM_OFS_MODEXT)
          serial_mode_extension <= (wd & `SPSM_MX_WMASK) |
                                   (`SPSM_MX_RST & ~`SPSM_MX_WMASK);
        else if (avs_address_i == `SPSM_OFS_IRQ_MASK)
          irq_mask <= wd[`SPSM_IRQ_W-1:0];
      end
      // Read data; unmapped addresses return zero
      avs_readdata_o <= 32'h0000_0000;
      if (req & avs_read_i) begin
        if (avs_address_i == `SPSM_OFS_MODE)
          avs_readdata_o <= {24'h000000, mode_reg};
        else if (avs_address_i == `SPSM_OFS_BRATE)
          avs_readdata_o <= {24'h000000, brate};
        else if (avs_address_i == `SPSM_OFS_CTRL)
          avs_readdata_o <= {24'h000000, serial_control_reg};
        else if (avs_address_i == `SPSM_OFS_TXDATA)
          avs_readdata_o <= {24'h000000, transmit_data_buffer};
        else if (avs_address_i == `SPSM_OFS_STAT)
          avs_readdata_o <= {24'h000000, stat};
        else if (avs_address_i == `SPSM_OFS_RXDATA)
          avs_readdata_o <= {24'h000000, receive_data_buffer};
        else if (avs_address_i == `SPSM_OFS_MODEXT)
          avs_readdata_o <= {24'h000000, serial_mode_extension};
        else if (avs_address_i == `SPSM_OFS_IRQ_STAT)
          avs_readdata_o <= {29'h0, irq_stat};
        else if (avs_address_i == `SPSM_OFS_IRQ_MASK)
          avs_readdata_o <= {29'h0, irq_mask};
      end
    end
  end

  // Interrupt outputs registered; request follows the live empty flag
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o          <= 1'b0;
      tx_empty_irq_o <= 1'b0;
    end else begin
      irq_o          <= |(irq_stat & irq_mask);
      tx_empty_irq_o <= tx_empty_flag &
                        serial_control_reg[`SPSM_CTRL_TIE];
    end
  end

endmodule

// File: verif/spsm_asserts.sv
/*
 Port assertions for the serial port status and mode block.
 Assumes it is bound to spsm_top and the register map of the hand-over.
*/
module spsm_asserts (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        rxd_i,
  input wire logic        sck_i,
  input wire logic        txd_o,
  input wire logic        sck_o,
  input wire logic        sck_oe_o,
  input wire logic        irq_o,
  input wire logic        tx_empty_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wa, ra, sync_q, tie_q;
  logic [2:0] mask_q;
  logic [1:0] seen, ok;
  // Completed accesses: the edge where waitrequest is seen low
  assign wa = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign ra = avs_read_i && !avs_waitrequest_o;
  // Shadow fields; seen and ok follow the read-then-zero-write clear
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_q <= 1'b0;
      tie_q  <= 1'b0;
      mask_q <= 3'h0;
      seen   <= 2'h0;
      ok     <= 2'h0;
    end else begin
      if (wa && avs_address_i == 6'h00)
        sync_q <= avs_writedata_i[7];
      if (wa && avs_address_i == 6'h08)
        tie_q <= avs_writedata_i[7];
      if (wa && avs_address_i == 6'h20)
        mask_q <= avs_writedata_i[2:0];
      if (ra && avs_address_i == 6'h10) begin
        seen <= avs_readdata_o[7:6];
        ok   <= 2'h0;
      end
      if (wa && avs_address_i == 6'h10)
        ok <= ok | (seen & ~avs_writedata_i[7:6]);
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Outputs are registered, so enables are looked at one or two back
  wait_answer_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  one_wait_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  idle_data_a: assert property (avs_waitrequest_o |->
    avs_readdata_o == 32'h0) else $error("read data outside answer");
  unmapped_read_a: assert property (ra && avs_address_i > 6'h20 |->
    avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  modext_fixed_a: assert property (ra && avs_address_i == 6'h18 |->
    avs_readdata_o[31:4] == 28'hf && avs_readdata_o[1])
    else $error("mode extension fixed bits wrong");
  tx_irq_gate_a: assert property (tx_empty_irq_o |->
    $past(tie_q) || $past(tie_q, 2)) else $error("request while disabled");
  sync_clock_a: assert property (sck_oe_o |->
    $past(sync_q) || $past(sync_q, 2)) else $error("clock driven in async");
  flag_hold_a: assert property (ra && avs_address_i == 6'h10 |->
    (avs_readdata_o[7:6] & seen & ~ok) == (seen & ~ok))
    else $error("status flag cleared without read and zero write");
  irq_masked_a: assert property (irq_o |->
    ($past(mask_q) | $past(mask_q, 2)) != 3'h0) else $error("masked irq");
endmodule

// File: verif/spsm_peer.sv
/*
 Far-side serial device: sends 8N1 frames on demand, captures frames.
 Assumes the bit rate divider is 0, so one bit lasts 16 clocks.
*/
module spsm_peer (
  input  wire logic       clk_i,
  input  wire logic       txd_i,
  output logic            rxd_o,
  output logic [7:0]      cap_o,
  output int              ncap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16;
  // Line idles high between frames
  initial begin
    rxd_o = 1'b1;
    ncap_o = 0;
  end
  // One asynchronous frame, wire bits sent from w[0] onward
  task send(input logic [7:0] w);
    rxd_o <= 1'b0;
    repeat (BIT) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      rxd_o <= w[k];
      repeat (BIT) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (BIT) @(posedge clk_i);
  endtask
  // Capture sampling mid bit; wire order kept in cap_o[0] onward
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT) @(posedge clk_i);
      cap_o[k] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    ncap_o++;
  end
endmodule

// File: verif/spsm_top_tb.sv
/*
 Self-checking bench for the serial port status and mode block.
 Assumes the register map and one-wait bus timing of the hand-over.
*/
module spsm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_b_i, avs_read_i, avs_write_i, sck_i;
  logic [5:0]  avs_address_i;
  logic [31:0] avs_writedata_i, d;
  logic [3:0]  avs_byteenable_i;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, rxd_i, txd_o, sck_o, sck_oe_o;
  wire         irq_o, tx_empty_irq_o;
  wire  [7:0]  cap;
  int          ncap, err_count, checks, n;
  spsm_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i), .sck_i(sck_i),
    .txd_o(txd_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .irq_o(irq_o),
    .tx_empty_irq_o(tx_empty_irq_o));
  spsm_peer peer (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i),
    .cap_o(cap), .ncap_o(ncap));
  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access; held until waitrequest is sampled low
  task acc(input logic w, input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, v};
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // Lets registered outputs land before they are looked at
  task settle;
    repeat (3) @(posedge clk_i);
  endtask
  // Line order of a byte for a given bit order and inversion
  function automatic logic [7:0] wire_of(input logic [7:0] v,
                                         input logic o, input logic i);
    logic [7:0] w;
    for (int b = 0; b < 8; b++) w[b] = o ? v[7 - b] : v[b];
    return i ? ~w : w;
  endfunction
  task t_reset;
    acc(0, 6'h10, 0);
    chk(d, 32'h04);
    acc(0, 6'h18, 0);
    chk(d, 32'hf2);
    acc(1, 6'h3c, 8'h55);
    acc(0, 6'h3c, 0);
    chk(d, 32'h0);
    acc(1, 6'h10, 8'hf8);
    acc(0, 6'h10, 0);
    chk(d, 32'h04);
    acc(1, 6'h18, 8'h0d);
    acc(0, 6'h18, 0);
    chk(d, 32'hff);
    acc(1, 6'h18, 0);
    acc(1, 6'h04, 0);
  endtask
  // Receive in all four order and inversion settings
  task t_rx;
    logic [7:0] v;
    acc(1, 6'h08, 8'h10);
    acc(1, 6'h20, 8'h02);
    for (int k = 0; k < 4; k++) begin
      v = 8'h16 + 8'(k) * 8'h31;
      acc(1, 6'h18, {4'h0, k[1:0], 2'b00});
      peer.send(wire_of(v, k[1], k[0]));
      for (n = 0; n < 100 && irq_o !== 1'b1; n++) @(posedge clk_i);
      chk(irq_o, 1);
      acc(1, 6'h10, 0);
      acc(0, 6'h10, 0);
      chk(d[6], 1);
      acc(1, 6'h10, 8'hff);
      acc(0, 6'h10, 0);
      chk(d[6], 1);
      acc(0, 6'h14, 0);
      chk(d, v);
      acc(1, 6'h10, 8'hbf);
      acc(0, 6'h10, 0);
      chk(d[6], 0);
      acc(1, 6'h1c, 8'h02);
      settle;
      chk(irq_o, 0);
    end
    acc(1, 6'h08, 0);
  endtask
  // Transmit MSB first; flag set, clear and interrupt gating
  task t_tx;
    acc(1, 6'h20, 0);
    acc(1, 6'h18, 8'h08);
    acc(1, 6'h0c, 8'ha5);
    acc(1, 6'h08, 8'ha0);
    acc(1, 6'h10, 0);
    acc(0, 6'h10, 0);
    chk(d[7], 1);
    settle;
    chk(tx_empty_irq_o, 1);
    chk(irq_o, 0);
    acc(0, 6'h1c, 0);
    chk(d[0], 1);
    acc(1, 6'h08, 8'h20);
    settle;
    chk(tx_empty_irq_o, 0);
    acc(1, 6'h10, 8'h7f);
    acc(0, 6'h10, 0);
    chk(d[7], 0);
    for (n = 0; n < 400 && ncap < 1; n++) @(posedge clk_i);
    chk(cap, wire_of(8'ha5, 1, 0));
    d = 0;
    for (n = 0; n < 40 && d[7] !== 1'b1; n++) acc(0, 6'h10, 0);
    chk(d[7], 1);
    acc(1, 6'h10, 8'h7f);
    acc(0, 6'h10, 0);
    chk(d[7], 0);
    acc(1, 6'h08, 0);
    acc(0, 6'h10, 0);
    chk(d[7], 1);
  endtask
  task t_sync;
    logic [7:0] w;
    acc(1, 6'h00, 8'h80);
    settle;
    chk(sck_oe_o, 1);
    // Clocked transfer, MSB first still set: bits taken at each clock rise
    acc(1, 6'h0c, 8'h3a);
    acc(0, 6'h10, 0);
    acc(1, 6'h10, 8'h7f);
    acc(1, 6'h08, 8'h20);
    for (int b = 0; b < 8; b++) begin
      @(posedge sck_o);
      w[b] = txd_o;
    end
    chk(w, wire_of(8'h3a, 1, 0));
    acc(1, 6'h08, 0);
    acc(1, 6'h18, 8'h01);
    settle;
    chk(sck_oe_o, 0);
    acc(1, 6'h18, 0);
    acc(1, 6'h00, 0);
    settle;
    chk(sck_oe_o, 0);
    chk(sck_o, 1);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence after an 8 cycle reset
  initial begin
    rst_b_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    sck_i = 1'b1;
    err_count = 0;
    checks = 0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_rx;
    t_tx;
    t_sync;
    tally_and_finish;
  end
  // Watchdog, well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    tally_and_finish;
  end
endmodule
bind spsm_top spsm_asserts chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i), .sck_i(sck_i),
  .txd_o(txd_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .irq_o(irq_o),
  .tx_empty_irq_o(tx_empty_irq_o));
